/* hw/ccm_capture_ctrl.sv */
// Capture mode sequencer: freerun, software/hardware trigger and standby.
// Registers on Avalon-MM; frame transfer handshake with the readout path.
`timescale 1ns/1ns
module ccm_capture_ctrl
	import ccm_pkg::*;
#(
	parameter int unsigned CNT_W = 32
)
(
	input  wire logic              clk_sys_i,
	input  wire logic              rst_n_i,
	input  wire logic [ADDR_W-1:0] avs_address_i,
	input  wire logic              avs_read_i,
	input  wire logic              avs_write_i,
	input  wire logic [DATA_W-1:0] avs_writedata_i,
	input  wire logic [3:0]        avs_byteenable_i,
	output logic      [DATA_W-1:0] avs_readdata_o,
	output logic                   avs_waitrequest_o,
	input  wire logic              hw_trigger_i,
	input  wire logic              xfer_done_i,
	output logic                   sensor_power_o,
	output logic                   expose_o,
	output logic                   frame_start_o,
	output logic                   frame_send_o,
	output logic                   frame_black_o,
	output logic                   flash_o,
	output logic      [GPO_W-1:0]  gpo_o
);

	if (CNT_W < 8 || CNT_W > DATA_W)
		$error("CNT_W must lie between 8 and DATA_W");

	logic [1:0] rst_sync_q;
	wire        rst_n = rst_sync_q[1];

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			rst_sync_q <= 2'h0;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end

	// Bus slave: one wait cycle per access, so read data come from a flop.
	logic              ack_q;
	logic [DATA_W-1:0] ctrl_q;
	logic [DATA_W-1:0] period_q;
	logic [DATA_W-1:0] expose_q;
	logic [DATA_W-1:0] rdata_q;
	logic [DROP_W-1:0] drop_q;
	logic              black_q;
	ccm_state_type     state_q;
	ccm_state_type     state_d;

	// A request is answered one cycle after it is first seen. The write lands at the edge
	// that sees waitrequest low, so a held request is applied exactly once.
	wire        req      = (avs_read_i | avs_write_i) & ~ack_q;
	wire        wr_fire  = avs_write_i & ack_q;
	wire        sel_ctrl = avs_address_i == CTRL_OFS;
	wire        sel_cmd  = avs_address_i == CMD_OFS;
	wire        sel_per  = avs_address_i == PERIOD_OFS;
	wire        sel_exp  = avs_address_i == EXPOSE_OFS;

	function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_v,
		input logic [DATA_W-1:0] new_v, input logic [3:0] be);
		logic [DATA_W-1:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[i*8 +: 8] = new_v[i*8 +: 8];
		return r;
	endfunction

	wire [DATA_W-1:0] ctrl_wd = merge(ctrl_q, avs_writedata_i, avs_byteenable_i);
	wire              cmd_wr  = wr_fire & sel_cmd & avs_byteenable_i[0];
	wire              cmd_single = cmd_wr & avs_writedata_i[CMD_SINGLE_BIT];
	wire              cmd_cont   = cmd_wr & avs_writedata_i[CMD_CONT_BIT];
	wire              cmd_stop   = cmd_wr & avs_writedata_i[CMD_STOP_BIT];
	wire              cmd_swtrig = cmd_wr & avs_writedata_i[CMD_SWTRIG_BIT];
	wire              ctrl_wr    = wr_fire & sel_ctrl;

	wire ccm_mode_type mode = ccm_mode_type'(ctrl_q[CTRL_MODE_LSB +: 2]);
	wire               host_open = ctrl_q[CTRL_OPEN_BIT];
	wire [FLASH_W-1:0] flash_cfg = ctrl_q[CTRL_FLASH_LSB +: FLASH_W];
	wire               flash_chg = ctrl_wr && (ctrl_wd[CTRL_FLASH_LSB +: FLASH_W] != flash_cfg);

	wire [DATA_W-1:0] status_w = {drop_q, 10'h000, ~(state_q == CCM_ST_STANDBY), black_q,
		1'b0, 3'(state_q)};
	wire [DATA_W-1:0] rd_mux = sel_ctrl ? ctrl_q :
		sel_cmd ? status_w :
		sel_per ? period_q :
		sel_exp ? expose_q : UNMAPPED_RD;

	always_ff @(posedge clk_sys_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ack_q   <= 1'b0;
			rdata_q <= UNMAPPED_RD;
		end
		else
		begin
			ack_q   <= req;
			rdata_q <= rd_mux;
		end
	end

	assign avs_readdata_o    = rdata_q;
	assign avs_waitrequest_o = ~ack_q;

	// Frame period and exposure each have their own register.
	always_ff @(posedge clk_sys_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_q   <= CTRL_RST;
			period_q <= PERIOD_RST;
			expose_q <= EXPOSE_RST;
		end
		else
		begin
			if (ctrl_wr)
				ctrl_q <= ctrl_wd;
			if (wr_fire && sel_per)
				period_q <= merge(period_q, avs_writedata_i, avs_byteenable_i);
			if (wr_fire && sel_exp)
				expose_q <= merge(expose_q, avs_writedata_i, avs_byteenable_i);
		end
	end

	// Hardware trigger: two-stage synchroniser, then rising edge detect.
	logic [2:0] trig_q;

	always_ff @(posedge clk_sys_i or negedge rst_n)
	begin
		if (!rst_n)
			trig_q <= 3'h0;
		else
			trig_q <= {trig_q[1:0], hw_trigger_i};
	end

	wire hw_evt = trig_q[1] & ~trig_q[2];

	// Capture arming: single or continuous request from the host.
	logic run_q;
	logic cont_q;
	logic frames_q;

	wire awake     = host_open || mode != CCM_MODE_STANDBY;
	wire is_trig   = mode == CCM_MODE_SWTRIG || mode == CCM_MODE_HWTRIG;
	// In software mode being armed is itself the trigger, so a single capture starts at once
	// and a continuous one fires again each time the sequencer returns to idle.
	// A software trigger command only counts when it arrives while a frame is busy.
	wire trig_evt  = (mode == CCM_MODE_SWTRIG) ? (cmd_swtrig || run_q) :
		(mode == CCM_MODE_HWTRIG) ? hw_evt : 1'b0;
	wire accept    = is_trig && run_q && trig_evt && state_q == CCM_ST_IDLE;
	wire busy      = state_q == CCM_ST_EXPOSE || state_q == CCM_ST_XFER;
	wire discard   = is_trig && trig_evt && !cmd_single && busy && !(run_q && cont_q
		&& mode == CCM_MODE_SWTRIG);

	logic [CNT_W-1:0] cnt_q;
	logic             done_q;
	wire  [CNT_W-1:0] exp_len = expose_q[CNT_W-1:0];
	wire  [CNT_W-1:0] per_len = period_q[CNT_W-1:0];
	wire              exp_end = cnt_q >= exp_len - CNT_W'(1);
	wire              fr_end  = cnt_q >= per_len - CNT_W'(1);
	wire              restart = flash_chg && mode == CCM_MODE_FREERUN && run_q && cont_q;
	wire              frame_done;

	// Freerun overlaps exposure with transfer, so a new frame starts on every period tick.
	wire fr_start = mode == CCM_MODE_FREERUN && run_q && state_q != CCM_ST_STANDBY
		&& (state_q == CCM_ST_IDLE || fr_end) && !restart;

	// A freerun frame is complete at the end of its period, whether or not another follows,
	// so a snap still hands over its one frame. A restart abandons the frame instead.
	assign frame_done = is_trig ? (state_q == CCM_ST_XFER && xfer_done_i) :
		state_q == CCM_ST_EXPOSE && fr_end && !restart;

	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			CCM_ST_STANDBY:
				if (awake)
					state_d = CCM_ST_IDLE;
			CCM_ST_IDLE:
				if (!awake)
					state_d = CCM_ST_STANDBY;
				else if (accept || fr_start)
					state_d = CCM_ST_EXPOSE;
			CCM_ST_EXPOSE:
				if (!awake)
					state_d = CCM_ST_STANDBY;
				else if (restart)
					state_d = CCM_ST_IDLE;
				else if (is_trig && exp_end)
					state_d = CCM_ST_XFER;
				else if (!is_trig && fr_end && !run_q)
					state_d = CCM_ST_IDLE;
			CCM_ST_XFER:
				if (!awake)
					state_d = CCM_ST_STANDBY;
				else if ((xfer_done_i || done_q) && fr_end)
					state_d = CCM_ST_IDLE;
			default:
				state_d = CCM_ST_IDLE;
		endcase
	end

	wire entering = state_d == CCM_ST_EXPOSE && (state_q != CCM_ST_EXPOSE || fr_start);
	wire to_xfer  = state_d == CCM_ST_XFER && state_q != CCM_ST_XFER;

	always_ff @(posedge clk_sys_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= CCM_ST_STANDBY;
			cnt_q   <= '0;
		end
		else
		begin
			state_q <= state_d;
			if (entering || to_xfer)
				cnt_q <= '0;
			else
				cnt_q <= cnt_q + CNT_W'(1);
		end
	end

	// The readout may report completion long before the period has run out, and it may do so
	// with a single-cycle pulse. The report is kept here until the transfer state is next entered.
	always_ff @(posedge clk_sys_i or negedge rst_n)
	begin
		if (!rst_n)
			done_q <= 1'b0;
		else if (to_xfer)
			done_q <= 1'b0;
		else if (state_q == CCM_ST_XFER && xfer_done_i)
			done_q <= 1'b1;
	end

	// Arming: single capture disarms when its frame starts; continuous stays armed.
	always_ff @(posedge clk_sys_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			run_q    <= 1'b0;
			cont_q   <= 1'b0;
			frames_q <= 1'b0;
			black_q  <= 1'b0;
			drop_q   <= '0;
		end
		else
		begin
			if (cmd_stop || !awake)
				run_q <= 1'b0;
			else if (cmd_single || cmd_cont)
				run_q <= 1'b1;
			else if (!cont_q && (accept || (fr_start && mode == CCM_MODE_FREERUN)))
				run_q <= 1'b0;
			if (cmd_single || cmd_cont)
				cont_q <= cmd_cont;
			if (!run_q || restart)
				frames_q <= 1'b0;
			else if (frame_done && mode == CCM_MODE_FREERUN)
				frames_q <= 1'b1;
			if (restart)
				black_q <= 1'b1;
			else if (to_xfer || (frame_done && !is_trig))
				black_q <= 1'b0;
			if (discard && drop_q != '1)
				drop_q <= drop_q + DROP_W'(1);
		end
	end

	// Outputs, all from flops.
	logic flash_q;
	logic start_q;
	logic send_q;
	logic blk_o_q;
	logic pwr_q;
	logic expo_q;

	// Power and exposure flags follow the next state so that they change with state_q.
	always_ff @(posedge clk_sys_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			flash_q <= 1'b0;
			start_q <= 1'b0;
			send_q  <= 1'b0;
			blk_o_q <= 1'b0;
			pwr_q   <= 1'b0;
			expo_q  <= 1'b0;
		end
		else
		begin
			pwr_q   <= state_d != CCM_ST_STANDBY;
			expo_q  <= state_d == CCM_ST_EXPOSE;
			flash_q <= state_d == CCM_ST_EXPOSE && flash_cfg != '0 && (is_trig || (frames_q && cont_q));
			start_q <= entering;
			send_q  <= to_xfer || (frame_done && !is_trig);
			blk_o_q <= black_q;
		end
	end

	assign sensor_power_o = pwr_q;
	assign expose_o       = expo_q;
	assign frame_start_o  = start_q;
	assign frame_send_o   = send_q;
	assign frame_black_o  = blk_o_q;
	assign flash_o        = flash_q;
	assign gpo_o          = ctrl_q[GPO_LSB +: GPO_W];

endmodule

/* hw/ccm_pkg.sv */
// Constants and types for the camera capture mode sequencer.
// Assumes a 100 MHz system clock and a 32-bit Avalon-MM register bus.
// Overview of operation
// - Freerun captures frames back to back, exposing while the previous frame transfers.
// - Frame period and exposure time are separate registers; writing one keeps the other.
// - Freerun drives flash only from the second frame onward.
// - Flash timing change during continuous freerun restarts the sequence; next frame is black.
// - Freerun single capture transfers only the next exposed frame, no automatic flash.
// - In trigger modes the sensor idles until a trigger event arrives.
// - Triggers come from a host software command or the hardware trigger input.
// - Software trigger single capture yields exactly one frame.
// - Software trigger continuous capture triggers repeatedly and streams every frame.
// - Hardware trigger single capture arms for one trigger, then disarms.
// - Hardware trigger continuous capture re-arms after each frame.
// - Triggers during exposure or transfer are discarded until transfer completes and the frame period ends.
// - Discarded triggers increment a counter readable by the host.
// - Triggered capture period is exposure plus one readout frame period.
// - Standby powers down the sensor only while no host session is open.
// - Standby is the default whenever no host session is open.
// - Standby is left on host open or on selecting freerun or trigger mode.
// - Trigger input and general outputs keep working in standby.
package ccm_pkg;

	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 32;

	// Byte addresses of the registers.
	localparam logic [ADDR_W-1:0] CTRL_OFS     = 4'h0;
	localparam logic [ADDR_W-1:0] CMD_OFS      = 4'h4;
	localparam logic [ADDR_W-1:0] PERIOD_OFS   = 4'h8;
	localparam logic [ADDR_W-1:0] EXPOSE_OFS   = 4'hc;

	// Read-only status lives at the command offset read back: handled by read mux.
	localparam logic [ADDR_W-1:0] STATUS_OFS   = 4'h4;

	// Control register fields.
	localparam int unsigned CTRL_MODE_LSB  = 0;
	localparam int unsigned CTRL_OPEN_BIT  = 2;
	localparam int unsigned CTRL_FLASH_LSB = 8;
	localparam int unsigned FLASH_W        = 8;
	localparam int unsigned GPO_LSB        = 16;
	localparam int unsigned GPO_W          = 4;

	// Command register bits, write-one pulses.
	localparam int unsigned CMD_SINGLE_BIT = 0;
	localparam int unsigned CMD_CONT_BIT   = 1;
	localparam int unsigned CMD_STOP_BIT   = 2;
	localparam int unsigned CMD_SWTRIG_BIT = 3;

	// Status register fields.
	localparam int unsigned ST_STATE_LSB   = 0;
	localparam int unsigned ST_BLACK_BIT   = 4;
	localparam int unsigned ST_PWR_BIT     = 5;
	localparam int unsigned ST_DROP_LSB    = 16;
	localparam int unsigned DROP_W         = 16;

	localparam logic [DATA_W-1:0] CTRL_RST   = 32'h0000_0000;
	localparam logic [DATA_W-1:0] PERIOD_RST = 32'h0000_0100;
	localparam logic [DATA_W-1:0] EXPOSE_RST = 32'h0000_0080;
	localparam logic [DATA_W-1:0] UNMAPPED_RD = 32'h0000_0000;

	typedef enum logic [1:0]
	{
		CCM_MODE_STANDBY = 2'h0,
		CCM_MODE_FREERUN = 2'h1,
		CCM_MODE_SWTRIG  = 2'h2,
		CCM_MODE_HWTRIG  = 2'h3
	} ccm_mode_type;

	typedef enum logic [2:0]
	{
		CCM_ST_STANDBY,
		CCM_ST_IDLE,
		CCM_ST_EXPOSE,
		CCM_ST_XFER
	} ccm_state_type;

endpackage

/* tb/ccm_xfer_model.sv */
// Readout partner: finishes each handed-over frame after a random delay.
// Assumes frame_send_i is a one-cycle pulse in the clk_sys_i domain.
`timescale 1ns/1ns
module ccm_xfer_model
(
	input  wire logic clk_sys_i,
	input  wire logic rst_n_i,
	input  wire logic frame_send_i,
	output logic      xfer_done_o
);
	int n;
	// Delays from 2 to 24 cycles give both prompt and stalled transfers.
	always @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			n <= 0;
			xfer_done_o <= 1'b0;
		end
		else
		begin
			xfer_done_o <= (n == 1);
			if (frame_send_i === 1'b1)
				n <= $urandom_range(2, 24);
			else if (n > 0)
				n <= n - 1;
		end
	end
endmodule

/* tb/ccm_capture_checker.sv */
// Port-level assertions for the capture sequencer.
// Assumes it is bound to ccm_capture_ctrl and sees only its ports.
`timescale 1ns/1ns
module ccm_capture_checker
	import ccm_pkg::*;
(
	input wire logic              clk_sys_i,
	input wire logic              rst_n_i,
	input wire logic [ADDR_W-1:0] avs_address_i,
	input wire logic              avs_read_i,
	input wire logic              avs_write_i,
	input wire logic              avs_waitrequest_o,
	input wire logic              expose_o,
	input wire logic              sensor_power_o,
	input wire logic              frame_start_o,
	input wire logic              frame_send_o,
	input wire logic              frame_black_o,
	input wire logic              flash_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	a_wait_answer: assert property ($rose(avs_read_i || avs_write_i) |=> !avs_waitrequest_o)
		else $error("bus answer late");
	a_wait_short: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("answer held too long");
	a_start_pulse: assert property (frame_start_o |=> !frame_start_o)
		else $error("start pulse too long");
	a_send_pulse: assert property (frame_send_o |=> !frame_send_o)
		else $error("send pulse too long");
	a_start_expose: assert property (frame_start_o |-> ##[0:1] expose_o)
		else $error("start without exposure");
	a_expose_power: assert property (expose_o |-> sensor_power_o)
		else $error("exposing while powered down");
	a_send_power: assert property (frame_send_o |-> sensor_power_o)
		else $error("frame sent in standby");
	a_flash_expose: assert property (flash_o |-> expose_o)
		else $error("flash outside exposure");
	c_send: cover property (frame_send_o);
	c_flash: cover property (flash_o);
	c_black: cover property (frame_black_o);
endmodule
bind ccm_capture_ctrl ccm_capture_checker i_ccm_capture_checker (.*);

/* tb/camera_capture_mode_control_tb.sv */
// Self-checking bench for the capture sequencer with a readout partner.
// Assumes the design answers each bus request with one low waitrequest cycle.
`timescale 1ns/1ns
module camera_capture_mode_control_tb
	import ccm_pkg::*;
;
	logic              clk_sys_i, rst_n_i, avs_read_i, avs_write_i, hw_trigger_i, xfer_done_i, bl;
	logic [ADDR_W-1:0] avs_address_i, ofs[4];
	logic [DATA_W-1:0] avs_writedata_i, avs_readdata_o, r, p, ex[4];
	logic              avs_waitrequest_o, sensor_power_o, expose_o, frame_start_o, frame_send_o;
	logic              frame_black_o, flash_o;
	logic [3:0]        avs_byteenable_i;
	logic [GPO_W-1:0]  gpo_o, g;
	int                miscompares, n_checks, frames, f0, fl, cyc;

	ccm_capture_ctrl i_ccm_capture_ctrl (.*);
	ccm_xfer_model i_ccm_xfer_model (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.frame_send_i(frame_send_o), .xfer_done_o(xfer_done_i));

	initial
	begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end

	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask
	task automatic acc(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= w;
		avs_read_i <= !w;
		@(posedge clk_sys_i);
		while (avs_waitrequest_o !== 1'b0) @(posedge clk_sys_i);
		r = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		@(posedge clk_sys_i);
	endtask
	task automatic chk(input string n, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] s);
		n_checks++;
		if (s !== e)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic cmd(input int b);
		acc(1'b1, CMD_OFS, 32'h1 << b);
	endtask
	task automatic trig();
		hw_trigger_i <= 1'b1;
		wt(4);
		hw_trigger_i <= 1'b0;
		wt(4);
	endtask
	function automatic logic [DATA_W-1:0] ctrl(logic [1:0] m, logic o, logic [7:0] f, logic [3:0] q);
		return {12'h000, q, f, 5'h00, o, m};
	endfunction
	task automatic wrap_up();
		if (miscompares == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// A stuck design ends the run here instead of hanging.
	always @(posedge clk_sys_i)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			miscompares++;
			wrap_up();
		end
		if (frame_send_o === 1'b1)
			frames++;
		if (flash_o === 1'b1 && fl < 0)
			fl = frames;
		if (frame_black_o === 1'b1)
			bl = 1'b1;
	end

	initial
	begin
		{rst_n_i, avs_read_i, avs_write_i, hw_trigger_i, bl} = '0;
		{avs_address_i, avs_writedata_i} = '0;
		avs_byteenable_i = 4'hf;
		fl = -1;
		void'($urandom(32'h5f75));
		ofs = '{CTRL_OFS, PERIOD_OFS, EXPOSE_OFS, 4'h1};
		ex = '{CTRL_RST, PERIOD_RST, EXPOSE_RST, UNMAPPED_RD};
		wt(16);
		rst_n_i <= 1'b1;
		wt(3);
		for (int i = 0; i < 4; i++)
		begin
			acc(1'b0, ofs[i], 32'h0);
			chk("reset value", ex[i], r);
		end
		acc(1'b0, STATUS_OFS, 32'h0);
		chk("standby power", 32'h0, 32'(r[ST_PWR_BIT]));
		p = $urandom_range(64, 96);
		acc(1'b1, PERIOD_OFS, p);
		acc(1'b0, EXPOSE_OFS, 32'h0);
		chk("exposure kept", EXPOSE_RST, r);
		acc(1'b1, EXPOSE_OFS, 32'h20);
		acc(1'b0, PERIOD_OFS, 32'h0);
		chk("period kept", p, r);
		g = $urandom_range(0, 15);
		acc(1'b1, CTRL_OFS, ctrl(2'h0, 1'b0, 8'h00, g));
		chk("gpo", 32'(g), 32'(gpo_o));
		acc(1'b1, CTRL_OFS, ctrl(2'h2, 1'b1, 8'h00, g));
		acc(1'b0, STATUS_OFS, 32'h0);
		chk("open power", 32'h1, 32'(r[ST_PWR_BIT]));
		f0 = frames;
		cmd(CMD_SINGLE_BIT);
		wt(10);
		cmd(CMD_SWTRIG_BIT);
		wt(390);
		chk("sw single", 32'h1, 32'(frames - f0));
		acc(1'b0, STATUS_OFS, 32'h0);
		chk("sw dropped", 32'h1, r >> ST_DROP_LSB);
		cmd(CMD_CONT_BIT);
		wt(600);
		chk("sw cont", 32'h1, 32'(frames - f0 >= 4));
		cmd(CMD_STOP_BIT);
		wt(300);
		acc(1'b1, CTRL_OFS, ctrl(2'h3, 1'b1, 8'h00, g));
		f0 = frames;
		cmd(CMD_SINGLE_BIT);
		trig();
		wt(300);
		trig();
		wt(300);
		chk("hw single", 32'h1, 32'(frames - f0));
		acc(1'b0, STATUS_OFS, 32'h0);
		p = r >> ST_DROP_LSB;
		cmd(CMD_CONT_BIT);
		f0 = frames;
		repeat (3)
		begin
			trig();
			trig();
			wt(300);
		end
		chk("hw cont", 32'h3, 32'(frames - f0));
		acc(1'b0, STATUS_OFS, 32'h0);
		chk("dropped", p + 3, r >> ST_DROP_LSB);
		cmd(CMD_STOP_BIT);
		acc(1'b1, CTRL_OFS, ctrl(2'h0, 1'b1, 8'h00, g));
		wt(300);
		acc(1'b1, CTRL_OFS, ctrl(2'h1, 1'b1, 8'h10, g));
		f0 = frames;
		fl = -1;
		cmd(CMD_CONT_BIT);
		wt(500);
		chk("freerun", 32'h1, 32'(frames - f0 >= 3));
		chk("flash start", 32'h1, 32'(fl > f0));
		bl = 1'b0;
		acc(1'b1, CTRL_OFS, ctrl(2'h1, 1'b1, 8'h20, g));
		wt(400);
		chk("black frame", 32'h1, 32'(bl));
		cmd(CMD_STOP_BIT);
		wt(300);
		f0 = frames;
		fl = -1;
		cmd(CMD_SINGLE_BIT);
		wt(300);
		chk("snap", 32'h1, 32'(frames - f0));
		chk("snap flash", 32'h1, 32'(fl < 0));
		acc(1'b1, CTRL_OFS, ctrl(2'h0, 1'b0, 8'h00, g));
		acc(1'b0, STATUS_OFS, 32'h0);
		chk("closed power", 32'h0, 32'(r[ST_PWR_BIT]));
		wrap_up();
	end
endmodule
